// [src/csd_regs.v]
// Channel state, gain and DC load diagnostic register bank for a two-channel amplifier
`timescale 1ns/1ps
`include "csd_defs.vh"
// Notes on behaviour
// - Two-bit requested state per channel: play, hi-Z, mute, diagnostics; resets hi-Z.
// - Read-only actual state per channel in bits 7-6 and 5-4; resets hi-Z.
// - Eight-bit gain per channel at 0x05 and 0x06; reset 0xcf is unity.
// - Gain 0.5 dB per step; 0xff is +24 dB, 0x07 -100 dB, below mutes.
// - Writing the abort bit high stops any diagnostic run in progress.
// - Bits 6 and 5 double ramp and settle durations respectively.
// - Line-output detection runs only while bit 1 is set.
// - With bit 0 clear, diagnostics start on leaving hi-Z and after faults.
// - With bit 0 set, diagnostics run only when requested explicitly.
// - Four-bit shorted-load threshold per channel, 0.5 ohm steps, resets to 1 ohm.
// - Four result flags per channel: ground, supply, open, shorted load.
// - Line-output-detected flag per channel in bits 3 and 2.
module csd_regs (
   // Clock and reset
   input wire clk_in,
   input wire reset_n_in,
   // Register access port from the control-bus front end
   input wire [7:0] reg_addr_in,
   input wire reg_write_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   // Per-channel fault events and analogue comparator results (asynchronous)
   input wire [1:0] chan_fault_in,
   input wire [1:0] meas_s2g_in,
   input wire [1:0] meas_s2p_in,
   input wire [1:0] meas_open_in,
   input wire [7:0] meas_load_code_in,
   input wire [1:0] meas_line_in,
   // Per-channel gain steering to the datapath and diagnostic busy flags
   output reg [7:0] ch1_gain_out,
   output reg [7:0] ch2_gain_out,
   output reg [1:0] gain_mute_out,
   output wire [1:0] diag_busy_out
);
   // ----------------------------------------
   // Storage
   // ----------------------------------------
   reg [7:0] channel_requested_state;
   reg [7:0] ch1_gain_code;
   reg [7:0] ch2_gain_code;
   reg [7:0] diag_control_main;
   reg [7:0] diag_short_thresholds;
   wire [7:0] diag_fault_results;
   wire [7:0] diag_line_level_results;
   wire [7:0] channel_actual_state;
   wire [1:0] first_channel_actual_state;
   wire [1:0] second_channel_actual_state;
   wire [3:0] ch1_flags;
   wire [3:0] ch2_flags;
   wire first_channel_line_level_flag;
   wire second_channel_line_level_flag;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Analogue side is asynchronous; two stages before any use
   reg [17:0] sync_a;
   reg [17:0] sync_b;
   reg [1:0] fault_prev;
   wire [1:0] fault_rise;
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         sync_a <= 18'h00000;
         sync_b <= 18'h00000;
         fault_prev <= 2'h0;
      end else begin
         sync_a <= {chan_fault_in, meas_s2g_in, meas_s2p_in, meas_open_in, meas_load_code_in, meas_line_in};
         sync_b <= sync_a;
         fault_prev <= sync_b[17:16];
      end
   end
   // A fault triggers one run on its rising edge, not continuously
   assign fault_rise = sync_b[17:16] & ~fault_prev;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Reserved fields are stored as written; host restores them
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         channel_requested_state <= `CSD_RST_REQ_STATE;
         ch1_gain_code <= `CSD_RST_GAIN;
         ch2_gain_code <= `CSD_RST_GAIN;
         diag_control_main <= `CSD_RST_DIAG_CTRL;
         diag_short_thresholds <= `CSD_RST_DIAG_THR;
      end else if (reg_write_in) begin
         case (reg_addr_in)
            `CSD_ADDR_REQ_STATE: channel_requested_state <= reg_wdata_in;
            `CSD_ADDR_CH1_GAIN: ch1_gain_code <= reg_wdata_in;
            `CSD_ADDR_CH2_GAIN: ch2_gain_code <= reg_wdata_in;
            // Abort bit stays set until the host clears it again
            `CSD_ADDR_DIAG_CTRL: diag_control_main <= reg_wdata_in;
            `CSD_ADDR_DIAG_THR: diag_short_thresholds <= reg_wdata_in;
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // Gain steering
   // ----------------------------------------
   // Code passed through as dB index; codes below the floor force mute
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         ch1_gain_out <= `CSD_RST_GAIN;
         ch2_gain_out <= `CSD_RST_GAIN;
         gain_mute_out <= 2'h0;
      end else begin
         ch1_gain_out <= ch1_gain_code;
         ch2_gain_out <= ch2_gain_code;
         gain_mute_out <= {ch2_gain_code < `CSD_GAIN_MUTE_BELOW, ch1_gain_code < `CSD_GAIN_MUTE_BELOW};
      end
   end

   // ----------------------------------------
   // Channel sequencers
   // ----------------------------------------
   csd_chan_diag u_ch1 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .requested_state_in(channel_requested_state[7:6]),
      .abort_in(diag_control_main[`CSD_BIT_ABORT]),
      .double_ramp_in(diag_control_main[`CSD_BIT_DBL_RAMP]),
      .double_settle_in(diag_control_main[`CSD_BIT_DBL_SETTLE]),
      .line_enable_in(diag_control_main[`CSD_BIT_LINE_EN]),
      .auto_inhibit_in(diag_control_main[`CSD_BIT_AUTO_INHIBIT]),
      .short_threshold_in(diag_short_thresholds[7:4]),
      .fault_event_in(fault_rise[0]),
      .meas_s2g_in(sync_b[14]),
      .meas_s2p_in(sync_b[12]),
      .meas_open_in(sync_b[10]),
      .meas_load_code_in(sync_b[9:6]),
      .meas_line_in(sync_b[1]),
      .actual_state_out(first_channel_actual_state),
      .fault_flags_out(ch1_flags),
      .line_flag_out(first_channel_line_level_flag),
      .diag_busy_out(diag_busy_out[0])
   );
   csd_chan_diag u_ch2 (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .requested_state_in(channel_requested_state[5:4]),
      .abort_in(diag_control_main[`CSD_BIT_ABORT]),
      .double_ramp_in(diag_control_main[`CSD_BIT_DBL_RAMP]),
      .double_settle_in(diag_control_main[`CSD_BIT_DBL_SETTLE]),
      .line_enable_in(diag_control_main[`CSD_BIT_LINE_EN]),
      .auto_inhibit_in(diag_control_main[`CSD_BIT_AUTO_INHIBIT]),
      .short_threshold_in(diag_short_thresholds[3:0]),
      .fault_event_in(fault_rise[1]),
      .meas_s2g_in(sync_b[15]),
      .meas_s2p_in(sync_b[13]),
      .meas_open_in(sync_b[11]),
      .meas_load_code_in(sync_b[5:2]),
      .meas_line_in(sync_b[0]),
      .actual_state_out(second_channel_actual_state),
      .fault_flags_out(ch2_flags),
      .line_flag_out(second_channel_line_level_flag),
      .diag_busy_out(diag_busy_out[1])
   );

   // ----------------------------------------
   // Read-only views
   // ----------------------------------------
   // Reserved state fields read as their reset code
   assign channel_actual_state = {first_channel_actual_state, second_channel_actual_state, 4'h5};
   assign diag_fault_results = {ch1_flags, ch2_flags};
   assign diag_line_level_results = {4'h0, first_channel_line_level_flag,
                                     second_channel_line_level_flag, 2'h0};

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Registered so data is a flop output; unmapped reads return zero
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         case (reg_addr_in)
            `CSD_ADDR_REQ_STATE: reg_rdata_out <= channel_requested_state;
            `CSD_ADDR_CH1_GAIN: reg_rdata_out <= ch1_gain_code;
            `CSD_ADDR_CH2_GAIN: reg_rdata_out <= ch2_gain_code;
            `CSD_ADDR_DIAG_CTRL: reg_rdata_out <= diag_control_main;
            `CSD_ADDR_DIAG_THR: reg_rdata_out <= diag_short_thresholds;
            `CSD_ADDR_DIAG_FAULT: reg_rdata_out <= diag_fault_results;
            `CSD_ADDR_DIAG_LINE: reg_rdata_out <= diag_line_level_results;
            `CSD_ADDR_ACT_STATE: reg_rdata_out <= channel_actual_state;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end
endmodule

// [src/csd_defs.vh]
// Register map, field positions, reset values and timing counts for the channel state and diagnostics bank
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH
// Register offsets
`define CSD_ADDR_REQ_STATE 8'h04
`define CSD_ADDR_CH1_GAIN 8'h05
`define CSD_ADDR_CH2_GAIN 8'h06
`define CSD_ADDR_DIAG_CTRL 8'h09
`define CSD_ADDR_DIAG_THR 8'h0a
`define CSD_ADDR_DIAG_FAULT 8'h0c
`define CSD_ADDR_DIAG_LINE 8'h0e
`define CSD_ADDR_ACT_STATE 8'h0f
// Reset values
`define CSD_RST_REQ_STATE 8'h55
`define CSD_RST_GAIN 8'hcf
`define CSD_RST_DIAG_CTRL 8'h00
`define CSD_RST_DIAG_THR 8'h11
`define CSD_RST_ACT_STATE 8'h55
// Channel state encodings
`define CSD_ST_PLAY 2'h0
`define CSD_ST_HIZ 2'h1
`define CSD_ST_MUTE 2'h2
`define CSD_ST_DIAG 2'h3
// Field positions in the diagnostics control register
`define CSD_BIT_ABORT 7
`define CSD_BIT_DBL_RAMP 6
`define CSD_BIT_DBL_SETTLE 5
`define CSD_BIT_LINE_EN 1
`define CSD_BIT_AUTO_INHIBIT 0
// Gain mapping: codes below this fully mute
`define CSD_GAIN_MUTE_BELOW 8'h07
// Highest defined shorted-load threshold code
`define CSD_THR_MAX 4'h9
// Diagnostic phase lengths in clock cycles (normal setting)
`define CSD_RAMP_CYCLES 16'h0100
`define CSD_SETTLE_CYCLES 16'h0100
`define CSD_MEAS_CYCLES 16'h0040
`define CSD_LINE_CYCLES 16'h0040
`endif

// [src/csd_chan_diag.v]
// One channel's state sequencer and DC load diagnostic run
`timescale 1ns/1ps
`include "csd_defs.vh"
module csd_chan_diag (
   // Clock and reset
   input wire clk_in,
   input wire reset_n_in,
   // Control from the register bank
   input wire [1:0] requested_state_in,
   input wire abort_in,
   input wire double_ramp_in,
   input wire double_settle_in,
   input wire line_enable_in,
   input wire auto_inhibit_in,
   input wire [3:0] short_threshold_in,
   // Analogue comparator results, already synchronised
   input wire fault_event_in,
   input wire meas_s2g_in,
   input wire meas_s2p_in,
   input wire meas_open_in,
   input wire [3:0] meas_load_code_in,
   input wire meas_line_in,
   // Results
   output reg [1:0] actual_state_out,
   output reg [3:0] fault_flags_out,
   output reg line_flag_out,
   output wire diag_busy_out
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_RAMP = 5'h02;
   localparam [4:0] S_SETTLE = 5'h04;
   localparam [4:0] S_MEAS = 5'h08;
   localparam [4:0] S_LINE = 5'h10;

   reg [4:0] state;
   reg [15:0] count;
   reg [1:0] prev_req;
   reg explicit_run;
   wire leave_hiz;
   wire auto_start;
   wire req_start;
   wire [15:0] ramp_len;
   wire [15:0] settle_len;

   localparam [15:0] RAMP_NORM = `CSD_RAMP_CYCLES;
   localparam [15:0] SETTLE_NORM = `CSD_SETTLE_CYCLES;

   // Doubling is a left shift of the normal phase length; top bit dropped on purpose
   assign ramp_len = double_ramp_in ? {RAMP_NORM[14:0], 1'b0} : RAMP_NORM;
   assign settle_len = double_settle_in ? {SETTLE_NORM[14:0], 1'b0} : SETTLE_NORM;
   assign leave_hiz = (prev_req == `CSD_ST_HIZ) && (requested_state_in != `CSD_ST_HIZ);
   // Automatic runs only while not inhibited
   assign auto_start = !auto_inhibit_in && (leave_hiz || fault_event_in);
   assign req_start = (requested_state_in == `CSD_ST_DIAG) && (prev_req != `CSD_ST_DIAG);
   assign diag_busy_out = (state != S_IDLE);

   // Sequencer; abort wins over any phase and holds off new starts while set
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         state <= S_IDLE;
         count <= 16'h0000;
         prev_req <= `CSD_ST_HIZ;
         explicit_run <= 1'b0;
         actual_state_out <= `CSD_ST_HIZ;
         fault_flags_out <= 4'h0;
         line_flag_out <= 1'b0;
      end else begin
         prev_req <= requested_state_in;
         if (abort_in) begin
            state <= S_IDLE;
            count <= 16'h0000;
            explicit_run <= 1'b0;
            actual_state_out <= `CSD_ST_HIZ;
         end else begin
            case (state)
               S_IDLE: begin
                  // A finished explicit run keeps reporting diagnostics until the request changes
                  if (requested_state_in != `CSD_ST_DIAG) begin
                     actual_state_out <= requested_state_in;
                  end
                  if (auto_start || req_start) begin
                     state <= S_RAMP;
                     count <= 16'h0000;
                     explicit_run <= req_start;
                     fault_flags_out <= 4'h0;
                     line_flag_out <= 1'b0;
                     actual_state_out <= `CSD_ST_DIAG;
                  end
               end
               S_RAMP: begin
                  count <= count + 16'h0001;
                  if (count >= ramp_len - 16'h0001) begin
                     state <= S_SETTLE;
                     count <= 16'h0000;
                  end
               end
               S_SETTLE: begin
                  count <= count + 16'h0001;
                  if (count >= settle_len - 16'h0001) begin
                     state <= S_MEAS;
                     count <= 16'h0000;
                  end
               end
               S_MEAS: begin
                  count <= count + 16'h0001;
                  if (count == `CSD_MEAS_CYCLES - 16'h0001) begin
                     // Order: ground, supply, open, shorted
                     fault_flags_out <= {meas_s2g_in, meas_s2p_in, meas_open_in,
                                         (meas_load_code_in <= short_threshold_in)};
                     count <= 16'h0000;
                     state <= line_enable_in ? S_LINE : S_IDLE;
                     if (!line_enable_in) begin
                        actual_state_out <= explicit_run ? `CSD_ST_DIAG : `CSD_ST_HIZ;
                     end
                  end
               end
               S_LINE: begin
                  count <= count + 16'h0001;
                  if (count == `CSD_LINE_CYCLES - 16'h0001) begin
                     line_flag_out <= meas_line_in;
                     state <= S_IDLE;
                     actual_state_out <= explicit_run ? `CSD_ST_DIAG : `CSD_ST_HIZ;
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// [tb/csd_regs_properties.sv]
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
// ----------------
// Port checker
// ----------------
module csd_regs_properties (
   // Clock and reset
   input wire clk_in,
   input wire reset_n_in,
   // Register access port
   input wire [7:0] reg_addr_in,
   input wire reg_write_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   // Gain and diagnostic outputs
   input wire [7:0] ch1_gain_out,
   input wire [7:0] ch2_gain_out,
   input wire [1:0] gain_mute_out,
   input wire [1:0] diag_busy_out
);
   reg abort_held;
   reg [15:0] run_cnt;
   wire wr_ctrl = reg_write_in && reg_addr_in == 8'h09;
   // Abort stays in force until written back; run length counted to judge phase sums
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         abort_held <= 1'b0;
         run_cnt <= 16'h0000;
      end else begin
         if (wr_ctrl)
            abort_held <= reg_wdata_in[7];
         run_cnt <= diag_busy_out[0] ? run_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_wr1;
      reg_write_in && reg_addr_in == 8'h05 ##1 !(reg_write_in && reg_addr_in == 8'h05);
   endsequence
   sequence s_wr2;
      reg_write_in && reg_addr_in == 8'h06 ##1 !(reg_write_in && reg_addr_in == 8'h06);
   endsequence
   sequence s_abort;
      wr_ctrl && reg_wdata_in[7];
   endsequence
   a_gain1_store: assert property (s_wr1 |-> ##1 ch1_gain_out == $past(reg_wdata_in, 2))
      else $error("channel one gain copy wrong");
   a_gain2_store: assert property (s_wr2 |-> ##1 ch2_gain_out == $past(reg_wdata_in, 2))
      else $error("channel two gain copy wrong");
   a_mute_map: assert property (gain_mute_out == {ch2_gain_out < 8'h07, ch1_gain_out < 8'h07})
      else $error("mute does not follow gain code");
   a_unmapped_zero: assert property (!(reg_addr_in inside {8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h0c, 8'h0e,
      8'h0f}) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_state_low: assert property (reg_addr_in == 8'h0f |=> reg_rdata_out[3:0] == 4'h5)
      else $error("state report low bits wrong");
   a_line_spare: assert property (reg_addr_in == 8'h0e |=>
      reg_rdata_out[7:4] == 4'h0 && reg_rdata_out[1:0] == 2'h0)
      else $error("line report spare bits set");
   a_abort_stop: assert property (s_abort |-> ##[1:4] diag_busy_out == 2'b00)
      else $error("abort did not stop run");
   a_abort_hold: assert property (abort_held [*4] |-> diag_busy_out == 2'b00)
      else $error("run active while abort held");
   a_run_length: assert property ($fell(diag_busy_out[0]) && !abort_held |-> run_cnt >= 16'h023f)
      else $error("diagnostic run too short");
endmodule
bind csd_regs csd_regs_properties csd_regs_properties_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .ch1_gain_out(ch1_gain_out), .ch2_gain_out(ch2_gain_out),
   .gain_mute_out(gain_mute_out), .diag_busy_out(diag_busy_out));

// [tb/csd_host.sv]
// Host controller model driving the register access port
`timescale 1ns/1ps
module csd_host (
   // Clock
   input wire clk_in,
   // Register access port
   output logic [7:0] reg_addr_out,
   output logic reg_write_out,
   output logic [7:0] reg_wdata_out,
   input wire [7:0] reg_rdata_in
);
   initial begin
      reg_addr_out = 8'h00;
      reg_write_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   // One strobe per byte; data scrambled once the strobe drops so stale data never looks valid
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_write_out = 1'b1;
      @(posedge clk_in);
      #1;
      reg_write_out = 1'b0;
      reg_wdata_out = ~d;
   endtask
   // Read data is registered, so it is taken one edge after the address
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      #1;
      reg_addr_out = a;
      @(posedge clk_in);
      #1;
      d = reg_rdata_in;
   endtask
endmodule

// [tb/csd_regs_test.sv]
// Self-checking bench for the channel state and diagnostics register bank
`timescale 1ns/1ps
module csd_regs_test;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [1:0] chan_fault_in = 2'b00;
   logic [1:0] meas_s2g_in = 2'b00;
   logic [1:0] meas_s2p_in = 2'b00;
   logic [1:0] meas_open_in = 2'b00;
   logic [7:0] meas_load_code_in = 8'hff;
   logic [1:0] meas_line_in = 2'b00;
   wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ch1_gain_out, ch2_gain_out;
   wire reg_write_in;
   wire [1:0] gain_mute_out, diag_busy_out;
   int n_errors = 0;
   int checked = 0;
   int n;
   logic [31:0] seed = 32'hdc22;
   logic [7:0] v, g;
   logic [7:0] rst_a [9] = '{8'h04, 8'h05, 8'h06, 8'h09, 8'h0a, 8'h0c, 8'h0e, 8'h0f, 8'h07};
   logic [7:0] rst_v [9] = '{8'h55, 8'hcf, 8'hcf, 8'h00, 8'h11, 8'h00, 8'h00, 8'h55, 8'h00};
   logic [7:0] ctl [5] = '{8'h01, 8'h03, 8'h41, 8'h21, 8'h63};
   csd_host csd_host_i (.clk_in(clk_in), .reg_addr_out(reg_addr_in), .reg_write_out(reg_write_in),
      .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));
   csd_regs csd_regs_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
      .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .chan_fault_in(chan_fault_in), .meas_s2g_in(meas_s2g_in), .meas_s2p_in(meas_s2p_in),
      .meas_open_in(meas_open_in), .meas_load_code_in(meas_load_code_in), .meas_line_in(meas_line_in),
      .ch1_gain_out(ch1_gain_out), .ch2_gain_out(ch2_gain_out), .gain_mute_out(gain_mute_out),
      .diag_busy_out(diag_busy_out));
   // ----------------
   // Helpers
   // ----------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // Expected run length from the phase settings
   function automatic int run_len(input logic [7:0] c);
      return (c[6] ? 512 : 256) + (c[5] ? 512 : 256) + 64 + (c[1] ? 64 : 0);
   endfunction
   task chk(input string s, input logic [15:0] e, input logic [15:0] got);
      checked++;
      if (got !== e) begin
         $display("Error %s expected %h seen %h", s, e, got);
         n_errors++;
      end
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      csd_host_i.rd(a, v);
      chk("register read", {8'h00, e & m}, {8'h00, v & m});
   endtask
   // Bounded wait on channel one busy; n tells how long it took
   task wait_busy(input logic val, input int lim);
      n = 0;
      while (diag_busy_out[0] !== val && n < lim) begin
         @(posedge clk_in);
         #1;
         n++;
      end
   endtask
   task finish_test;
      $display("Comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // Span is about 35 times the longest expected run of all scenarios
   initial begin
      #200000;
      n_errors++;
      finish_test;
   end
   // ----------------
   // Scenarios
   // ----------------
   initial begin
      repeat (6) @(posedge clk_in);
      #1;
      reset_n_in = 1'b1;
      foreach (rst_a[i]) rchk(rst_a[i], rst_v[i], 8'hff);
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         g = (i == 0) ? 8'h06 : (i == 1) ? 8'h07 : (i == 2) ? 8'hff : seed[7:0];
         csd_host_i.wr(8'h05, g);
         csd_host_i.wr(8'h06, ~g);
         rchk(8'h06, ~g, 8'hff);
         chk("gain one", {8'h00, g}, {8'h00, ch1_gain_out});
         chk("gain two", {8'h00, ~g}, {8'h00, ch2_gain_out});
         chk("mute", {14'h0, ~g < 8'h07, g < 8'h07}, {14'h0, gain_mute_out});
      end
      // Writes to read-only and unmapped places are dropped
      csd_host_i.wr(8'h0f, 8'h00);
      csd_host_i.wr(8'h0b, 8'hff);
      rchk(8'h0f, 8'h55, 8'hff);
      rchk(8'h0b, 8'h00, 8'hff);
      csd_host_i.wr(8'h0a, 8'h39);
      rchk(8'h0a, 8'h39, 8'hff);
      // Requested runs with normal, doubled-ramp, doubled-settle and both-doubled phase lengths, line detect on and off
      foreach (ctl[i]) begin
         seed = xs(seed);
         meas_s2g_in[0] = seed[0];
         meas_s2p_in[0] = seed[1];
         meas_open_in[0] = seed[2];
         meas_line_in[1] = seed[3];
         meas_load_code_in[7:4] = seed[7:4];
         csd_host_i.wr(8'h09, ctl[i]);
         csd_host_i.wr(8'h04, 8'h55);
         csd_host_i.wr(8'h04, 8'hf5);
         wait_busy(1'b1, 20);
         chk("busy two", 16'h1, {15'h0, diag_busy_out[1]});
         wait_busy(1'b0, 3000);
         chk("run length", 16'h1, {15'h0, n >= run_len(ctl[i]) && n <= run_len(ctl[i]) + 16});
         rchk(8'h0c, {seed[0], seed[1], seed[2], seed[7:4] <= 4'h3, 4'h0}, 8'hff);
         rchk(8'h0e, {4'h0, seed[3] & ctl[i][1], 3'h0}, 8'hff);
         rchk(8'h0f, 8'hf5, 8'hff);
         rchk(8'h04, 8'hf5, 8'hff);
      end
      // Abort in mid-run, then the host puts the bit back
      csd_host_i.wr(8'h04, 8'h55);
      csd_host_i.wr(8'h04, 8'hf5);
      wait_busy(1'b1, 20);
      repeat (100) @(posedge clk_in);
      csd_host_i.wr(8'h09, 8'h81);
      wait_busy(1'b0, 6);
      chk("abort stop", 16'h1, {15'h0, n < 6});
      csd_host_i.wr(8'h09, 8'h01);
      // Automatic runs on leaving high impedance and on a fault
      csd_host_i.wr(8'h04, 8'h55);
      csd_host_i.wr(8'h09, 8'h00);
      csd_host_i.wr(8'h04, 8'h15);
      wait_busy(1'b1, 12);
      chk("auto start", 16'h1, {15'h0, n < 12});
      wait_busy(1'b0, 3000);
      chan_fault_in = 2'b01;
      wait_busy(1'b1, 12);
      chk("fault start", 16'h1, {15'h0, n < 12});
      chan_fault_in = 2'b00;
      wait_busy(1'b0, 3000);
      // With the inhibit bit set neither trigger starts a run
      csd_host_i.wr(8'h09, 8'h01);
      csd_host_i.wr(8'h04, 8'h55);
      csd_host_i.wr(8'h04, 8'h15);
      chan_fault_in = 2'b01;
      wait_busy(1'b1, 20);
      chk("no auto start", 16'h0014, n[15:0]);
      rchk(8'h0f, 8'h15, 8'hff);
      // Reset in mid-run stops both sequencers and restores the reset values
      chan_fault_in = 2'b00;
      csd_host_i.wr(8'h04, 8'hf5);
      wait_busy(1'b1, 20);
      repeat (50) @(posedge clk_in);
      #1;
      reset_n_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      reset_n_in = 1'b1;
      chk("reset busy", 16'h0, {14'h0, diag_busy_out});
      rchk(8'h0f, 8'h55, 8'hff);
      rchk(8'h04, 8'h55, 8'hff);
      rchk(8'h0a, 8'h11, 8'hff);
      finish_test;
   end
endmodule
